// [spi_ctl_pkg.sv]
// shared constants and helpers for the serial control port
package spi_ctl_pkg;
	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int HDR_BITS = 16;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [14:0] CFG_ADDR = 15'h000;
	localparam logic [14:0] BSEL_ADDR = 15'h008;
	localparam logic [14:0] PAGE_LO_ADDR = 15'h013;
	localparam logic [14:0] PAGE_HI_ADDR = 15'h014;
	localparam logic [14:0] BEAM_V_ADDR = 15'h081;
	localparam logic [14:0] BEAM_H_ADDR = 15'h082;
	localparam logic [14:0] GSRAM_BASE = 15'h0c0;
	localparam logic [14:0] PSRAM_BASE = 15'h100;
	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CFG_SOFT_RST_BIT = 0;
	localparam int CFG_SDO_EN_BIT = 3;
	localparam int CFG_ASCEND_BIT = 5;
	localparam int CFG_LSB_FIRST_BIT = 6;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] BSEL_LO = 8'h01;
	localparam logic [7:0] BSEL_HI = 8'h02;
	localparam logic [7:0] BSEL_RST = 8'h01;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] BEAM_RST = 8'h00;
	localparam logic [1:0] LOAD_TOGGLES = 2'h3;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 5;
	localparam int SDO_DLY_NS = 7;
	localparam logic [1:0] SDO_DLY_CYC = 2'((SDO_DLY_NS + CLK_NS - 1) / CLK_NS);
	localparam int HOST_HALF_CYC = 16;
	// ----------------------------------------------------------------
	// bit order helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
			r[i] = v[7 - i];
		return r;
	endfunction : rev8
	function automatic logic [14:0] rev15(input logic [14:0] v);
		logic [14:0] r;
		r = '0;
		for (int i = 0; i < 15; i++)
			r[i] = v[14 - i];
		return r;
	endfunction : rev15
endpackage : spi_ctl_pkg

// [spi_link_if.sv]
// serial control link between controller and beamformer port
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic sclk;
	logic cs_n;
	logic host_sdio_o;
	logic host_sdio_oe_n;
	logic dev_sdio_o;
	logic dev_sdio_oe_n;
	logic dev_sdo_o;
	logic dev_sdo_oe_n;
	logic sdio;
	logic serial_data_out;
	logic hrst_n;
	logic load_v;
	logic load_h;
	logic dir_v;
	logic dir_h;
	logic [3:0] chip_id;
	logic proto_sel;
	// ----------------------------------------------------------------
	// wire levels, pulled high when nobody drives
	// ----------------------------------------------------------------
	assign sdio = !dev_sdio_oe_n ? dev_sdio_o : (!host_sdio_oe_n ? host_sdio_o : 1'b1);
	assign serial_data_out = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;
	modport dev (
		input sclk, cs_n, sdio, hrst_n, load_v, load_h, dir_v, dir_h, chip_id, proto_sel,
		output dev_sdio_o, dev_sdio_oe_n, dev_sdo_o, dev_sdo_oe_n
	);
	modport host (
		input sdio, serial_data_out,
		output sclk, cs_n, host_sdio_o, host_sdio_oe_n, hrst_n, load_v, load_h, dir_v, dir_h,
		output chip_id, proto_sel
	);
endinterface : spi_link_if
`default_nettype wire

// [spi_port_dev.sv]
// beamformer serial control port, device end
`timescale 1ns/1ps
`default_nettype none
module spi_port_dev #(
	parameter bit DUAL = 1'b1,
	parameter int PDEPTH = 4,
	parameter int GDEPTH = 4
) (
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	spi_link_if.dev LINK,
	output logic [15:0] TX_MODE_O,
	output logic [7:0] BEAM_V_O,
	output logic [7:0] BEAM_H_O
);
	localparam int PI_W = $clog2(PDEPTH);
	localparam int GI_W = $clog2(GDEPTH);
	// ----------------------------------------------------------------
	// input synchronisers and edges
	// ----------------------------------------------------------------
	logic [12:0] s1_r, s2_r, s3_r;
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
		begin
			s1_r <= 13'h0a00;
			s2_r <= 13'h0a00;
			s3_r <= 13'h0a00;
		end
		else
		begin
			s1_r <= {LINK.sclk, LINK.cs_n, LINK.sdio, LINK.hrst_n, LINK.load_v, LINK.load_h,
				LINK.dir_v, LINK.dir_h, LINK.proto_sel, LINK.chip_id};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	logic sel, rise, fall, din, hard;
	logic [1:0] load_edge, dir_rise, dir_fall;
	assign sel = !s2_r[11] && !s2_r[4] && s2_r[3:0] == 4'h0;
	assign rise = sel && s2_r[12] && !s3_r[12];
	assign fall = sel && !s2_r[12] && s3_r[12];
	assign din = s2_r[10];
	assign hard = !s2_r[9];
	assign load_edge[0] = s2_r[8] ^ s3_r[8];
	assign load_edge[1] = DUAL ? (s2_r[7] ^ s3_r[7]) : load_edge[0];
	assign dir_rise[0] = s2_r[6] && !s3_r[6];
	assign dir_fall[0] = !s2_r[6] && s3_r[6];
	assign dir_rise[1] = DUAL ? (s2_r[5] && !s3_r[5]) : dir_rise[0];
	assign dir_fall[1] = DUAL ? (!s2_r[5] && s3_r[5]) : dir_fall[0];
	// ----------------------------------------------------------------
	// frame shifter
	// ----------------------------------------------------------------
	logic [7:0] cfg_r, bsel_r;
	logic [15:0] page_r;
	logic [14:0] hdr_r, addr_r, wr_addr_r;
	logic [7:0] dsh_r, wr_data_r;
	logic [3:0] hcnt_r;
	logic [2:0] dcnt_r;
	logic hdr_done_r, rw_r, wr_go_r, fetch_r;
	logic lsb, asc;
	logic [15:0] hdr_full;
	logic [7:0] byte_in;
	assign lsb = cfg_r[spi_ctl_pkg::CFG_LSB_FIRST_BIT];
	assign asc = cfg_r[spi_ctl_pkg::CFG_ASCEND_BIT];
	assign hdr_full = {hdr_r, din};
	assign byte_in = lsb ? spi_ctl_pkg::rev8({dsh_r[6:0], din}) : {dsh_r[6:0], din};
	always_ff @(posedge CLOCK_I)
		if (RESET_I || !sel)
		begin
			hcnt_r <= 4'h0;
			dcnt_r <= 3'h0;
			hdr_done_r <= 1'b0;
			hdr_r <= 15'h0000;
			dsh_r <= 8'h00;
			rw_r <= 1'b0;
			addr_r <= 15'h0000;
			wr_go_r <= 1'b0;
			fetch_r <= 1'b0;
			wr_addr_r <= 15'h0000;
			wr_data_r <= 8'h00;
		end
		else
		begin
			wr_go_r <= 1'b0;
			fetch_r <= 1'b0;
			if (rise && !hdr_done_r)
			begin
				hdr_r <= hdr_full[14:0];
				hcnt_r <= hcnt_r + 4'h1;
				if (hcnt_r == 4'hf)
				begin
					hdr_done_r <= 1'b1;
					rw_r <= hdr_full[15] == spi_ctl_pkg::RW_READ;
					addr_r <= lsb ? spi_ctl_pkg::rev15(hdr_full[14:0]) : hdr_full[14:0];
					fetch_r <= hdr_full[15] == spi_ctl_pkg::RW_READ;
				end
			end
			else if (rise)
			begin
				dsh_r <= {dsh_r[6:0], din};
				dcnt_r <= dcnt_r + 3'h1;
				if (dcnt_r == 3'h7)
				begin
					wr_go_r <= !rw_r;
					wr_addr_r <= addr_r;
					wr_data_r <= byte_in;
					addr_r <= asc ? addr_r + 15'h0001 : addr_r - 15'h0001;
					fetch_r <= rw_r;
				end
			end
		end
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic [14:0] poff, goff;
	logic w_p, w_g, w_lo, w_hi, soft_r, std_rst;
	assign poff = wr_addr_r - spi_ctl_pkg::PSRAM_BASE;
	assign goff = wr_addr_r - spi_ctl_pkg::GSRAM_BASE;
	assign w_p = wr_go_r && wr_addr_r >= spi_ctl_pkg::PSRAM_BASE && poff < 15'(PDEPTH);
	assign w_g = wr_go_r && wr_addr_r >= spi_ctl_pkg::GSRAM_BASE && goff < 15'(GDEPTH);
	assign w_lo = bsel_r == spi_ctl_pkg::BSEL_LO;
	assign w_hi = bsel_r == spi_ctl_pkg::BSEL_HI;
	assign std_rst = RESET_I || hard || soft_r;
	// ----------------------------------------------------------------
	// standard registers
	// ----------------------------------------------------------------
	logic [7:0] beam_hold_r [2];
	always_ff @(posedge CLOCK_I)
		if (std_rst)
		begin
			cfg_r <= spi_ctl_pkg::CFG_RST;
			bsel_r <= spi_ctl_pkg::BSEL_RST;
			page_r <= {spi_ctl_pkg::PAGE_RST, spi_ctl_pkg::PAGE_RST};
			beam_hold_r[0] <= spi_ctl_pkg::BEAM_RST;
			beam_hold_r[1] <= spi_ctl_pkg::BEAM_RST;
		end
		else if (wr_go_r)
			unique case (wr_addr_r)
				spi_ctl_pkg::CFG_ADDR: cfg_r <= wr_data_r;
				spi_ctl_pkg::BSEL_ADDR: bsel_r <= wr_data_r;
				spi_ctl_pkg::PAGE_LO_ADDR: page_r[7:0] <= wr_data_r;
				spi_ctl_pkg::PAGE_HI_ADDR: page_r[15:8] <= wr_data_r;
				spi_ctl_pkg::BEAM_V_ADDR: beam_hold_r[0] <= wr_data_r;
				spi_ctl_pkg::BEAM_H_ADDR: beam_hold_r[1] <= wr_data_r;
				default: ;
			endcase
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
			soft_r <= 1'b0;
		else
			soft_r <= wr_go_r && wr_addr_r == spi_ctl_pkg::CFG_ADDR
				&& wr_data_r[spi_ctl_pkg::CFG_SOFT_RST_BIT];
	// ----------------------------------------------------------------
	// sram banks
	// ----------------------------------------------------------------
	logic [15:0] psram_r [16][PDEPTH];
	logic [15:0] gsram_r [GDEPTH];
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
		begin
			for (int c = 0; c < 16; c++)
				for (int e = 0; e < PDEPTH; e++)
					psram_r[c][e] <= 16'h0000;
		end
		else if (w_p)
			for (int c = 0; c < 16; c++)
				if (page_r[c])
				begin
					if (w_lo)
						psram_r[c][poff[PI_W-1:0]][7:0] <= wr_data_r;
					if (w_hi)
						psram_r[c][poff[PI_W-1:0]][15:8] <= wr_data_r;
				end
	always_ff @(posedge CLOCK_I)
		if (RESET_I || hard)
		begin
			for (int e = 0; e < GDEPTH; e++)
				gsram_r[e] <= 16'h0000;
		end
		else if (w_g)
		begin
			if (w_lo)
				gsram_r[goff[GI_W-1:0]][7:0] <= wr_data_r;
			if (w_hi)
				gsram_r[goff[GI_W-1:0]][15:8] <= wr_data_r;
		end
	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [15:0] rd_word;
	logic [7:0] rd_byte;
	logic rd_sram;
	logic [14:0] rpo, rgo;
	assign rpo = addr_r - spi_ctl_pkg::PSRAM_BASE;
	assign rgo = addr_r - spi_ctl_pkg::GSRAM_BASE;
	always_comb
	begin
		logic found;
		found = 1'b0;
		rd_word = 16'h0000;
		rd_sram = 1'b0;
		rd_byte = 8'h00;
		if (addr_r >= spi_ctl_pkg::PSRAM_BASE && rpo < 15'(PDEPTH))
		begin
			rd_sram = 1'b1;
			for (int c = 0; c < 16; c++)
				if (page_r[c] && !found)
				begin
					found = 1'b1;
					rd_word = psram_r[c][rpo[PI_W-1:0]];
				end
		end
		else if (addr_r >= spi_ctl_pkg::GSRAM_BASE && rgo < 15'(GDEPTH))
		begin
			rd_sram = 1'b1;
			rd_word = gsram_r[rgo[GI_W-1:0]];
		end
		else
			unique case (addr_r)
				spi_ctl_pkg::CFG_ADDR: rd_byte = cfg_r;
				spi_ctl_pkg::BSEL_ADDR: rd_byte = bsel_r;
				spi_ctl_pkg::PAGE_LO_ADDR: rd_byte = page_r[7:0];
				spi_ctl_pkg::PAGE_HI_ADDR: rd_byte = page_r[15:8];
				spi_ctl_pkg::BEAM_V_ADDR: rd_byte = beam_hold_r[0];
				spi_ctl_pkg::BEAM_H_ADDR: rd_byte = beam_hold_r[1];
				default: rd_byte = 8'h00;
			endcase
		if (rd_sram)
			rd_byte = w_hi ? rd_word[15:8] : (w_lo ? rd_word[7:0] : 8'h00);
	end
	// ----------------------------------------------------------------
	// read data output
	// ----------------------------------------------------------------
	logic [7:0] tx_sh_r, sram_hold_r;
	logic [1:0] pend_r;
	logic drv_r;
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
			sram_hold_r <= 8'h00;
		else if (fetch_r && rd_sram)
			sram_hold_r <= rd_byte;
	always_ff @(posedge CLOCK_I)
		if (RESET_I || !sel)
		begin
			tx_sh_r <= 8'h00;
			pend_r <= 2'h0;
			drv_r <= 1'b0;
			LINK.dev_sdio_o <= 1'b0;
			LINK.dev_sdo_o <= 1'b0;
			LINK.dev_sdio_oe_n <= 1'b1;
			LINK.dev_sdo_oe_n <= 1'b1;
		end
		else
		begin
			if (fetch_r)
				tx_sh_r <= lsb ? spi_ctl_pkg::rev8(rd_sram ? sram_hold_r : rd_byte)
					: (rd_sram ? sram_hold_r : rd_byte);
			else if (pend_r == 2'h1)
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			if (fall && hdr_done_r && rw_r)
				pend_r <= spi_ctl_pkg::SDO_DLY_CYC;
			else if (pend_r != 2'h0)
				pend_r <= pend_r - 2'h1;
			if (pend_r == 2'h1)
			begin
				drv_r <= 1'b1;
				LINK.dev_sdio_o <= tx_sh_r[7];
				LINK.dev_sdo_o <= tx_sh_r[7];
				LINK.dev_sdio_oe_n <= cfg_r[spi_ctl_pkg::CFG_SDO_EN_BIT];
				LINK.dev_sdo_oe_n <= !cfg_r[spi_ctl_pkg::CFG_SDO_EN_BIT];
			end
		end
	// ----------------------------------------------------------------
	// load strobes and direction
	// ----------------------------------------------------------------
	logic [1:0] lcnt_r [2];
	always_ff @(posedge CLOCK_I)
		if (std_rst)
		begin
			lcnt_r[0] <= 2'h0;
			lcnt_r[1] <= 2'h0;
			BEAM_V_O <= spi_ctl_pkg::BEAM_RST;
			BEAM_H_O <= spi_ctl_pkg::BEAM_RST;
		end
		else
			for (int g = 0; g < 2; g++)
				if (load_edge[g])
				begin
					if (lcnt_r[g] == spi_ctl_pkg::LOAD_TOGGLES - 2'h1)
					begin
						lcnt_r[g] <= 2'h0;
						if (g == 0)
							BEAM_V_O <= beam_hold_r[0];
						else
							BEAM_H_O <= beam_hold_r[1];
					end
					else
						lcnt_r[g] <= lcnt_r[g] + 2'h1;
				end
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
			TX_MODE_O <= 16'h0000;
		else
			for (int c = 0; c < 16; c++)
				if (dir_rise[c % 2])
					TX_MODE_O[c] <= 1'b1;
				else if (dir_fall[c % 2])
					TX_MODE_O[c] <= 1'b0;
endmodule : spi_port_dev
`default_nettype wire

// [spi_port_host.sv]
// controller end of the beamformer serial control port
`timescale 1ns/1ps
`default_nettype none
module spi_port_host #(
	parameter int HALF = spi_ctl_pkg::HOST_HALF_CYC
) (
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	spi_link_if.host LINK,
	input wire logic START_I,
	input wire logic RW_I,
	input wire logic [14:0] ADDR_I,
	input wire logic [3:0] NBYTES_I,
	input wire logic [7:0] WR_DATA_I,
	input wire logic LSB_FIRST_I,
	input wire logic FOUR_WIRE_I,
	input wire logic LOAD_V_REQ_I,
	input wire logic LOAD_H_REQ_I,
	input wire logic DIR_V_I,
	input wire logic DIR_H_I,
	input wire logic HARD_RST_I,
	output logic WR_TAKE_O,
	output logic [7:0] RD_DATA_O,
	output logic RD_VALID_O,
	output logic BUSY_O
);
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b11, ST_END = 2'b10}
		state_e;
	state_e st_r;
	logic [1:0] sd1_r, sd2_r;
	logic [7:0] div_r, bit_r, last_r;
	logic [15:0] tsh_r;
	logic [7:0] wsh_r, rsh_r;
	logic rw_r, lsb_r, din;
	logic [7:0] nxt_bit;
	// ----------------------------------------------------------------
	// read data synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
		begin
			sd1_r <= 2'h3;
			sd2_r <= 2'h3;
		end
		else
		begin
			sd1_r <= {LINK.serial_data_out, LINK.sdio};
			sd2_r <= sd1_r;
		end
	assign din = FOUR_WIRE_I ? sd2_r[1] : sd2_r[0];
	assign nxt_bit = bit_r + 8'h01;
	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
		begin
			st_r <= ST_IDLE;
			div_r <= 8'h00;
			bit_r <= 8'h00;
			last_r <= 8'h00;
			tsh_r <= 16'h0000;
			wsh_r <= 8'h00;
			rsh_r <= 8'h00;
			rw_r <= 1'b0;
			lsb_r <= 1'b0;
			LINK.sclk <= 1'b0;
			LINK.cs_n <= 1'b1;
			LINK.host_sdio_o <= 1'b0;
			LINK.host_sdio_oe_n <= 1'b1;
			WR_TAKE_O <= 1'b0;
			RD_DATA_O <= 8'h00;
			RD_VALID_O <= 1'b0;
			BUSY_O <= 1'b0;
		end
		else
		begin
			WR_TAKE_O <= 1'b0;
			RD_VALID_O <= 1'b0;
			div_r <= div_r + 8'h01;
			unique case (st_r)
				ST_IDLE:
				begin
					div_r <= 8'h00;
					if (START_I)
					begin
						st_r <= ST_LOW;
						BUSY_O <= 1'b1;
						rw_r <= RW_I;
						lsb_r <= LSB_FIRST_I;
						bit_r <= 8'h00;
						last_r <= 8'(spi_ctl_pkg::HDR_BITS + 8 * (int'(NBYTES_I) + 1) - 1);
						tsh_r <= {RW_I, LSB_FIRST_I ? spi_ctl_pkg::rev15(ADDR_I) : ADDR_I};
						LINK.cs_n <= 1'b0;
						LINK.host_sdio_o <= RW_I;
						LINK.host_sdio_oe_n <= 1'b0;
					end
				end
				ST_LOW:
					if (div_r == 8'(HALF - 1))
					begin
						st_r <= ST_HIGH;
						div_r <= 8'h00;
						LINK.sclk <= 1'b1;
						if (rw_r && bit_r >= 8'(spi_ctl_pkg::HDR_BITS))
						begin
							rsh_r <= {rsh_r[6:0], din};
							if (bit_r[2:0] == 3'h7)
							begin
								RD_DATA_O <= lsb_r ? spi_ctl_pkg::rev8({rsh_r[6:0], din})
									: {rsh_r[6:0], din};
								RD_VALID_O <= 1'b1;
							end
						end
					end
				ST_HIGH:
					if (div_r == 8'(HALF - 1))
					begin
						div_r <= 8'h00;
						LINK.sclk <= 1'b0;
						bit_r <= nxt_bit;
						if (bit_r == last_r)
						begin
							st_r <= ST_END;
							LINK.cs_n <= 1'b1;
							LINK.host_sdio_oe_n <= 1'b1;
						end
						else
						begin
							st_r <= ST_LOW;
							if (nxt_bit < 8'(spi_ctl_pkg::HDR_BITS))
							begin
								tsh_r <= {tsh_r[14:0], 1'b0};
								LINK.host_sdio_o <= tsh_r[14];
							end
							else if (rw_r)
								LINK.host_sdio_oe_n <= 1'b1;
							else if (nxt_bit[2:0] == 3'h0)
							begin
								wsh_r <= LSB_FIRST_I ? spi_ctl_pkg::rev8(WR_DATA_I) : WR_DATA_I;
								LINK.host_sdio_o <= LSB_FIRST_I ? WR_DATA_I[0] : WR_DATA_I[7];
								WR_TAKE_O <= 1'b1;
							end
							else
							begin
								wsh_r <= {wsh_r[6:0], 1'b0};
								LINK.host_sdio_o <= wsh_r[6];
							end
						end
					end
				ST_END:
					if (div_r == 8'(HALF - 1))
					begin
						st_r <= ST_IDLE;
						BUSY_O <= 1'b0;
					end
			endcase
		end
	// ----------------------------------------------------------------
	// load strobes, direction, straps and reset pin
	// ----------------------------------------------------------------
	logic [1:0] lreq, lpin;
	logic [1:0] lleft_r [2];
	logic [7:0] ltim_r [2];
	assign lreq = {LOAD_H_REQ_I, LOAD_V_REQ_I};
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
			for (int g = 0; g < 2; g++)
			begin
				lleft_r[g] <= 2'h0;
				ltim_r[g] <= 8'h00;
				lpin[g] <= 1'b0;
			end
		else
			for (int g = 0; g < 2; g++)
				if (lleft_r[g] == 2'h0)
				begin
					ltim_r[g] <= 8'h00;
					if (lreq[g])
						lleft_r[g] <= spi_ctl_pkg::LOAD_TOGGLES;
				end
				else if (ltim_r[g] == 8'(HALF - 1))
				begin
					ltim_r[g] <= 8'h00;
					lpin[g] <= !lpin[g];
					lleft_r[g] <= lleft_r[g] - 2'h1;
				end
				else
					ltim_r[g] <= ltim_r[g] + 8'h01;
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
		begin
			LINK.load_v <= 1'b0;
			LINK.load_h <= 1'b0;
			LINK.dir_v <= 1'b0;
			LINK.dir_h <= 1'b0;
			LINK.hrst_n <= 1'b1;
			LINK.chip_id <= 4'h0;
			LINK.proto_sel <= 1'b0;
		end
		else
		begin
			LINK.load_v <= lpin[0];
			LINK.load_h <= lpin[1];
			LINK.dir_v <= DIR_V_I;
			LINK.dir_h <= DIR_H_I;
			LINK.hrst_n <= !HARD_RST_I;
			LINK.chip_id <= 4'h0;
			LINK.proto_sel <= 1'b0;
		end
endmodule : spi_port_host
`default_nettype wire

// [spi_port_properties.sv]
// assertions on the serial control link
`timescale 1ns/1ps
`default_nettype none
module spi_port_properties (
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic host_sdio_oe_n,
	input wire logic dev_sdio_oe_n,
	input wire logic dev_sdo_oe_n,
	input wire logic load_v,
	input wire logic [3:0] chip_id,
	input wire logic proto_sel
);
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (RESET_I);
	// ----------------------------------------------------------------
	// load strobe steps
	// ----------------------------------------------------------------
	// cycles since the last load pin change, so only a burst's first toggle starts a check
	logic [5:0] quiet_r;
	always_ff @(posedge CLOCK_I)
		if (RESET_I)
			quiet_r <= 6'h3f;
		else if ($changed(load_v))
			quiet_r <= 6'h00;
		else if (quiet_r != 6'h3f)
			quiet_r <= quiet_r + 6'h01;
	sequence s_load_first;
		quiet_r > 6'h14 && $changed(load_v);
	endsequence
	sequence s_load_rest;
		##[15:17] $changed(load_v) ##[15:17] $changed(load_v);
	endsequence
	// ----------------------------------------------------------------
	// link properties
	// ----------------------------------------------------------------
	property p_no_clash;
		!(dev_sdio_oe_n == 1'b0 && host_sdio_oe_n == 1'b0);
	endproperty
	property p_one_pin;
		!dev_sdo_oe_n |-> dev_sdio_oe_n;
	endproperty
	property p_release;
		cs_n [*5] |-> dev_sdio_oe_n && dev_sdo_oe_n;
	endproperty
	property p_drive_in_frame;
		($fell(dev_sdio_oe_n) || $fell(dev_sdo_oe_n)) |-> !cs_n;
	endproperty
	property p_sclk_idle;
		cs_n |-> !sclk;
	endproperty
	property p_straps;
		chip_id == 4'h0;
	endproperty
	property p_proto;
		!proto_sel;
	endproperty
	property p_load_three;
		s_load_first |-> s_load_rest;
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive the data pin");
	a_one_pin: assert property (p_one_pin)
		else $error("device drives both data pins");
	a_release: assert property (p_release)
		else $error("data pins held after deselect");
	a_drive_in_frame: assert property (p_drive_in_frame)
		else $error("device drives outside a frame");
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock high while deselected");
	a_straps: assert property (p_straps)
		else $error("straps not grounded");
	a_proto: assert property (p_proto)
		else $error("protocol select high");
	a_load_three: assert property (p_load_three)
		else $error("load strobe not toggled three times");
endmodule : spi_port_properties
`default_nettype wire

// [beamformer_spi_control_port_tb_top.sv]
// testbench for the beamformer serial control port
`timescale 1ns/1ps
`default_nettype none
module beamformer_spi_control_port_tb_top;
	logic CLOCK_I = 1'b0;
	logic RESET_I = 1'b1;
	logic st = 1'b0, rw = 1'b0, lsb = 1'b0, fw = 1'b0, ldv = 1'b0, ldh = 1'b0;
	logic dv = 1'b0, dh = 1'b0, hrst = 1'b0;
	logic [14:0] addr = '0;
	logic [3:0] nbytes = '0;
	logic [7:0] wdata = '0;
	logic wr_take, rd_valid, busy;
	logic [7:0] rd_data, beam_v, beam_h;
	logic [15:0] tx_mode;
	logic [7:0] wd [2];
	logic [7:0] rd [2];
	logic [23:0] sh = '0;
	int nbits = 0;
	int failures = 0;
	int n_checks = 0;
	always #2.5 CLOCK_I = ~CLOCK_I;
	spi_link_if link_if ();
	spi_port_host #(.HALF(16)) spi_port_host_inst (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
		.LINK(link_if.host), .START_I(st), .RW_I(rw), .ADDR_I(addr), .NBYTES_I(nbytes),
		.WR_DATA_I(wdata), .LSB_FIRST_I(lsb), .FOUR_WIRE_I(fw), .LOAD_V_REQ_I(ldv),
		.LOAD_H_REQ_I(ldh), .DIR_V_I(dv), .DIR_H_I(dh), .HARD_RST_I(hrst),
		.WR_TAKE_O(wr_take), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .BUSY_O(busy));
	spi_port_dev spi_port_dev_inst (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .LINK(link_if.dev),
		.TX_MODE_O(tx_mode), .BEAM_V_O(beam_v), .BEAM_H_O(beam_h));
	spi_port_properties spi_port_properties_inst (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
		.sclk(link_if.sclk), .cs_n(link_if.cs_n), .host_sdio_oe_n(link_if.host_sdio_oe_n),
		.dev_sdio_oe_n(link_if.dev_sdio_oe_n), .dev_sdo_oe_n(link_if.dev_sdo_oe_n),
		.load_v(link_if.load_v), .chip_id(link_if.chip_id), .proto_sel(link_if.proto_sel));
	// ----------------------------------------------------------------
	// wire monitor
	// ----------------------------------------------------------------
	always @(negedge link_if.cs_n) nbits = 0;
	always @(posedge link_if.sclk)
		if (link_if.cs_n === 1'b0)
		begin
			sh = {sh[22:0], link_if.sdio};
			nbits++;
		end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n) @(posedge CLOCK_I);
	endtask : ticks
	task automatic frame(input logic r, input logic [14:0] a, input int n);
		int k;
		int j;
		int t;
		k = 0;
		j = 0;
		t = 0;
		rd[0] = 8'hxx;
		@(posedge CLOCK_I);
		rw <= r;
		addr <= a;
		nbytes <= 4'(n - 1);
		wdata <= wd[0];
		st <= 1'b1;
		@(posedge CLOCK_I);
		st <= 1'b0;
		while ((t < 3 || busy !== 1'b0) && t < 4000)
		begin
			@(posedge CLOCK_I);
			t++;
			if (wr_take === 1'b1)
			begin
				k++;
				wdata <= wd[k % 2];
			end
			if (rd_valid === 1'b1)
			begin
				rd[j % 2] = rd_data;
				j++;
			end
		end
		if (t >= 4000)
			failures++;
	endtask : frame
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		wd[0] = d;
		frame(1'b0, a, 1);
	endtask : wr
	task automatic rdc(input string nm, input logic [14:0] a, input logic [7:0] e, input bit two);
		if (two)
			frame(1'b1, a, 1);
		frame(1'b1, a, 1);
		chk(nm, {16'h0000, e}, {16'h0000, rd[0]});
	endtask : rdc
	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		#300us;
		failures++;
		results();
	end
	initial
	begin
		ticks(3);
		RESET_I <= 1'b0;
		ticks(4);
		rdc("cfg", 15'h000, 8'h00, 0);
		rdc("bsel", 15'h008, 8'h01, 0);
		wr(15'h008, 8'h02);
		chk("frame bits", {1'b0, 15'h008, 8'h02}, sh);
		chk("frame length", 24'h000018, 24'(nbits));
		wr(15'h000, 8'h08);
		fw <= 1'b1;
		rdc("bsel four wire", 15'h008, 8'h02, 0);
		wd[1] = 8'h3c;
		wd[0] = 8'ha5;
		frame(1'b0, 15'h014, 2);
		rdc("page hi", 15'h014, 8'ha5, 0);
		rdc("page lo", 15'h013, 8'h3c, 0);
		wr(15'h100, 8'hc6);
		rdc("paged sram", 15'h100, 8'hc6, 1);
		wr(15'h0c0, 8'h77);
		rdc("global sram", 15'h0c0, 8'h77, 1);
		wr(15'h000, 8'h01);
		fw <= 1'b0;
		rdc("cfg soft", 15'h000, 8'h00, 0);
		rdc("bsel soft", 15'h008, 8'h01, 0);
		wr(15'h008, 8'h02);
		wr(15'h013, 8'h04);
		rdc("paged soft", 15'h100, 8'hc6, 1);
		rdc("global soft", 15'h0c0, 8'h77, 1);
		hrst <= 1'b1;
		ticks(10);
		hrst <= 1'b0;
		ticks(6);
		rdc("bsel hard", 15'h008, 8'h01, 0);
		wr(15'h008, 8'h02);
		rdc("global hard", 15'h0c0, 8'h00, 1);
		rdc("page hard", 15'h013, 8'h00, 0);
		wr(15'h013, 8'h04);
		rdc("paged hard", 15'h100, 8'hc6, 1);
		wr(15'h000, 8'h60);
		lsb <= 1'b1;
		wr(15'h008, 8'h02);
		chk("lsb frame", {1'b0, 15'h0800, 8'h40}, sh);
		rdc("bsel lsb", 15'h008, 8'h02, 0);
		wd[0] = 8'h11;
		wd[1] = 8'h22;
		frame(1'b0, 15'h013, 2);
		rdc("page asc hi", 15'h014, 8'h22, 0);
		rdc("page asc lo", 15'h013, 8'h11, 0);
		wr(15'h081, 8'h5a);
		wr(15'h082, 8'hc3);
		chk("beam v held", 24'h000000, {16'h0000, beam_v});
		ldv <= 1'b1;
		ticks(1);
		ldv <= 1'b0;
		ticks(80);
		chk("beam v", 24'h00005a, {16'h0000, beam_v});
		chk("beam h held", 24'h000000, {16'h0000, beam_h});
		ldh <= 1'b1;
		ticks(1);
		ldh <= 1'b0;
		ticks(80);
		chk("beam h", 24'h0000c3, {16'h0000, beam_h});
		dv <= 1'b1;
		ticks(8);
		chk("tx even", 24'h005555, {8'h00, tx_mode});
		dh <= 1'b1;
		ticks(8);
		chk("tx all", 24'h00ffff, {8'h00, tx_mode});
		dv <= 1'b0;
		ticks(8);
		chk("tx odd", 24'h00aaaa, {8'h00, tx_mode});
		results();
	end
endmodule : beamformer_spi_control_port_tb_top
`default_nettype wire
